/* File: inc/pfdc_cfg_if.sv */
interface pfdc_cfg_if;
  pfdc_pkg::pfdc_byte_t p2_selpri;
  pfdc_pkg::pfdc_grid_t claim;
  pfdc_pkg::pfdc_grid_t per_out;
  pfdc_pkg::pfdc_grid_t per_oe;
  pfdc_pkg::pfdc_grid_t grant;
  pfdc_pkg::pfdc_byte_t pin_out;
  pfdc_pkg::pfdc_byte_t pin_oe;
  pfdc_pkg::pfdc_byte_t pin_held;
  modport core (output p2_selpri, output claim, output per_out, output per_oe,
                input grant, input pin_out, input pin_oe, input pin_held);
  modport arb  (input p2_selpri, input claim, input per_out, input per_oe,
                output grant, output pin_out, output pin_oe, output pin_held);
  modport p2   (input p2_selpri);
endinterface

/* File: inc/pfdc_map.svh */
`ifndef PFDC_MAP_SVH
`define PFDC_MAP_SVH
// Register indices; byte address is four times the index
`define PFDC_IDX_LOC_CFG      8'hf1
`define PFDC_IDX_PORT1_FUNC   8'hf4
`define PFDC_IDX_PORT2_SELPRI 8'hf5
`define PFDC_IDX_GRANT_STAT   8'hf9
`define PFDC_IDX_PORT0_DIR    8'hfd
`define PFDC_IDX_PORT1_DIR    8'hfe
// Reset values
`define PFDC_RST_REG          8'h00
`define PFDC_RST_OE_N         8'hff
`define PFDC_RST_P2_OE_N      5'h1f
// Writable bits; the rest read as zero
`define PFDC_P2_WMASK         8'h7f
`define PFDC_LOC_WMASK        8'h73
// Fields of the port-2 select and precedence register
`define PFDC_B_PRI_SER_PAIR   6
`define PFDC_B_PRI_SER1_TMR3  5
`define PFDC_B_PRI_TMR1_TMR4  4
`define PFDC_B_PRI_SER0_TMR1  3
`define PFDC_B_P2_PIN4        2
`define PFDC_B_P2_PIN3        1
`define PFDC_B_P2_PIN0        0
// Claimant slots on port 1, lower slot wins unlisted pairs
`define PFDC_SRC_SER0         0
`define PFDC_SRC_SER1         1
`define PFDC_SRC_TMR1         2
`define PFDC_SRC_TMR3         3
`define PFDC_SRC_TMR4         4
`endif

/* File: inc/pfdc_pkg.sv */
package pfdc_pkg;
  // Bus handshake states, one-hot
  typedef enum logic [1:0] {
    PFDC_BUS_IDLE = 2'b01,
    PFDC_BUS_ACK  = 2'b10
  } pfdc_bus_e;
  typedef logic [7:0] pfdc_byte_t;
  typedef logic [39:0] pfdc_grid_t;
endpackage

/* File: rtl/pfdc_p1_arb.sv */
`include "pfdc_map.svh"
module pfdc_p1_arb (
  pfdc_cfg_if.arb cfg  // Precedence bits, claims and results
);
  // True when the lower slot lo beats the higher slot hi
  function automatic logic lo_wins(input int lo, input int hi, input logic [7:0] pri);
    logic r;
    r = 1'b1;
    if (lo == `PFDC_SRC_SER0 && hi == `PFDC_SRC_SER1)
      r = !pri[`PFDC_B_PRI_SER_PAIR];
    if (lo == `PFDC_SRC_SER1 && hi == `PFDC_SRC_TMR3)
      r = !pri[`PFDC_B_PRI_SER1_TMR3];
    if (lo == `PFDC_SRC_TMR1 && hi == `PFDC_SRC_TMR4)
      r = !pri[`PFDC_B_PRI_TMR1_TMR4];
    if (lo == `PFDC_SRC_SER0 && hi == `PFDC_SRC_TMR1)
      r = !pri[`PFDC_B_PRI_SER0_TMR1];
    return r;
  endfunction

  // Per pin, a claimant loses if any other claimant beats it
  for (genvar p = 0; p < 8; p++) begin : g_pin
    logic [4:0] clm;
    logic [4:0] beaten;
    logic [4:0] win;
    logic [4:0] pick;
    logic [4:0] outs;
    logic [4:0] oes;
    for (genvar i = 0; i < 5; i++) begin : g_src
      logic [4:0] hit;
      assign clm[i]  = cfg.claim[i*8+p];
      assign outs[i] = cfg.per_out[i*8+p];
      assign oes[i]  = cfg.per_oe[i*8+p];
      for (genvar j = 0; j < 5; j++) begin : g_oth
        if (j == i) begin : g_self
          assign hit[j] = 1'b0;
        end else if (j < i) begin : g_lo
          assign hit[j] = cfg.claim[j*8+p] && lo_wins(j, i, cfg.p2_selpri);
        end else begin : g_hi
          assign hit[j] = cfg.claim[j*8+p] && !lo_wins(i, j, cfg.p2_selpri);
        end
      end
      assign beaten[i] = |hit;
      assign cfg.grant[i*8+p] = pick[i];
    end
    // A precedence cycle leaves no winner; fall back to the lowest slot
    assign win  = clm & ~beaten;
    assign pick = (|win) ? (win & (~win + 5'h01)) : (clm & (~clm + 5'h01));
    assign cfg.pin_out[p]  = |(pick & outs);
    assign cfg.pin_oe[p]   = |(pick & oes);
    assign cfg.pin_held[p] = |clm;
  end
endmodule

/* File: rtl/pfdc_p2_mux.sv */
`include "pfdc_map.svh"
module pfdc_p2_mux (
  pfdc_cfg_if.p2     cfg,       // Port-2 function bits
  input  wire logic [4:0] gp_data,   // Port-2 data latch
  input  wire logic [4:0] gp_dir,    // Port-2 direction, 1 output
  input  wire logic [4:0] per_out,   // Peripheral pin values
  input  wire logic [4:0] per_oe,    // Peripheral drive requests
  input  wire logic       lfosc_sel, // Low-frequency oscillator in use
  input  wire logic       dbg_act,   // Debug interface active
  input  wire logic       dbg_dout,  // Debug data returned to host
  input  wire logic       dbg_drive, // Debug drives the data pin
  output logic      [4:0] pad_out,   // Pad value
  output logic      [4:0] pad_drv,   // Pad driven, active high
  output logic      [4:0] pad_ana    // Pad in analog mode
);
  logic [4:0] func;
  logic [4:0] sel_out;
  logic [4:0] sel_drv;

  // Only pins 0, 3 and 4 have a function bit
  assign func[0] = cfg.p2_selpri[`PFDC_B_P2_PIN0];
  assign func[1] = 1'b0;
  assign func[2] = 1'b0;
  assign func[3] = cfg.p2_selpri[`PFDC_B_P2_PIN3];
  assign func[4] = cfg.p2_selpri[`PFDC_B_P2_PIN4];

  assign sel_out = (func & per_out) | (~func & gp_data);
  assign sel_drv = (func & per_oe) | (~func & gp_dir);

  // Debug owns pins 1 and 2; clock pin is input, data pin driven on return
  assign pad_out[0] = sel_out[0];
  assign pad_drv[0] = sel_drv[0];
  assign pad_out[1] = dbg_act ? dbg_dout : sel_out[1];
  assign pad_drv[1] = dbg_act ? dbg_drive : sel_drv[1];
  assign pad_out[2] = dbg_act ? 1'b0 : sel_out[2];
  assign pad_drv[2] = dbg_act ? 1'b0 : sel_drv[2];
  // Crystal pins ignore every setting while the oscillator uses them
  assign pad_out[3] = lfosc_sel ? 1'b0 : sel_out[3];
  assign pad_drv[3] = lfosc_sel ? 1'b0 : sel_drv[3];
  assign pad_out[4] = lfosc_sel ? 1'b0 : sel_out[4];
  assign pad_drv[4] = lfosc_sel ? 1'b0 : sel_drv[4];
  assign pad_ana    = {lfosc_sel, lfosc_sel, 3'h0};
endmodule

/* File: rtl/pfdc_top.sv */
`include "pfdc_map.svh"
module pfdc_top (
  input  wire logic        CLK,             // System clock
  input  wire logic        SRST,            // Synchronous reset, active high
  input  wire logic [9:0]  AVS_ADDRESS,     // Byte address
  input  wire logic        AVS_READ,        // Read request
  input  wire logic        AVS_WRITE,       // Write request
  input  wire logic [31:0] AVS_WRITEDATA,   // Write data
  input  wire logic [3:0]  AVS_BYTEENABLE,  // Byte lanes
  output logic      [31:0] AVS_READDATA,    // Read data
  output logic             AVS_WAITREQUEST, // Stall, active high
  output logic      [7:0]  LOC_CFG,         // Peripheral location bits
  input  wire logic [7:0]  P0_DATA,         // Port-0 data latch
  input  wire logic [7:0]  P0_FUNC,         // Port-0 function select
  input  wire logic [7:0]  P0_PER_OUT,      // Port-0 peripheral values
  input  wire logic [7:0]  P0_PER_OE,       // Port-0 peripheral drive
  output logic      [7:0]  P0_PAD_OUT,      // Port-0 pad value
  output logic      [7:0]  P0_PAD_OE_N,     // Port-0 pad enable, low drives
  input  wire logic [7:0]  P1_DATA,         // Port-1 data latch
  input  wire logic [39:0] PER_CLAIM,       // Port-1 claims, slot*8+pin
  input  wire logic [39:0] PER_OUT,         // Port-1 peripheral values
  input  wire logic [39:0] PER_OE,          // Port-1 peripheral drive
  output logic      [39:0] PER_GRANT,       // Port-1 pins won per slot
  output logic      [7:0]  P1_PAD_OUT,      // Port-1 pad value
  output logic      [7:0]  P1_PAD_OE_N,     // Port-1 pad enable, low drives
  input  wire logic [4:0]  P2_DATA,         // Port-2 data latch
  input  wire logic [4:0]  P2_DIR,          // Port-2 direction
  input  wire logic [4:0]  P2_PER_OUT,      // Port-2 peripheral values
  input  wire logic [4:0]  P2_PER_OE,       // Port-2 peripheral drive
  input  wire logic        LFOSC_SEL,       // Low-frequency oscillator in use
  input  wire logic        DBG_ACTIVE,      // Debug interface active
  input  wire logic        DBG_DATA_OUT,    // Debug data to host
  input  wire logic        DBG_DATA_DRIVE,  // Debug drives data pin
  output logic      [4:0]  P2_PAD_OUT,      // Port-2 pad value
  output logic      [4:0]  P2_PAD_OE_N,     // Port-2 pad enable, low drives
  output logic      [4:0]  P2_ANALOG        // Port-2 analog mode
);
  pfdc_cfg_if cfg ();

  pfdc_pkg::pfdc_bus_e  state;
  pfdc_pkg::pfdc_bus_e  next_state;
  pfdc_pkg::pfdc_byte_t port1_function_select;
  pfdc_pkg::pfdc_byte_t port2_select_and_priority;
  pfdc_pkg::pfdc_byte_t port0_direction;
  pfdc_pkg::pfdc_byte_t port1_direction;
  pfdc_pkg::pfdc_byte_t peripheral_location_config;

  logic [7:0]  index;
  logic        req;
  logic        wr_hit;
  logic [7:0]  wr_byte;
  logic        wr_p1_func;
  logic        wr_p2_selpri;
  logic        wr_p0_dir;
  logic        wr_p1_dir;
  logic        wr_loc;
  logic [7:0]  rd_byte;
  logic [31:0] next_readdata;
  logic        next_waitrequest;

  logic [7:0]  next_p0_out;
  logic [7:0]  next_p0_drv;
  logic [7:0]  next_p1_out;
  logic [7:0]  next_p1_drv;
  logic [4:0]  p2_out;
  logic [4:0]  p2_drv;
  logic [4:0]  p2_ana;

  // Register index from the byte address; low two bits are ignored
  assign index   = AVS_ADDRESS[9:2];
  assign req     = AVS_READ | AVS_WRITE;
  assign wr_byte = AVS_WRITEDATA[7:0];

  // Writes land at the edge where waitrequest is seen low
  assign wr_hit       = (state == pfdc_pkg::PFDC_BUS_ACK) && AVS_WRITE && AVS_BYTEENABLE[0];
  assign wr_p1_func   = wr_hit && (index == `PFDC_IDX_PORT1_FUNC);
  assign wr_p2_selpri = wr_hit && (index == `PFDC_IDX_PORT2_SELPRI);
  assign wr_p0_dir    = wr_hit && (index == `PFDC_IDX_PORT0_DIR);
  assign wr_p1_dir    = wr_hit && (index == `PFDC_IDX_PORT1_DIR);
  assign wr_loc       = wr_hit && (index == `PFDC_IDX_LOC_CFG);

  // Read mux; unmapped indices answer zero
  always_comb begin
    unique case (index)
      `PFDC_IDX_PORT1_FUNC:   rd_byte = port1_function_select;
      `PFDC_IDX_PORT2_SELPRI: rd_byte = port2_select_and_priority;
      `PFDC_IDX_PORT0_DIR:    rd_byte = port0_direction;
      `PFDC_IDX_PORT1_DIR:    rd_byte = port1_direction;
      `PFDC_IDX_LOC_CFG:      rd_byte = peripheral_location_config;
      `PFDC_IDX_GRANT_STAT:   rd_byte = cfg.pin_held;
      default:                rd_byte = 8'h00;
    endcase
  end
  assign next_readdata = {24'h000000, rd_byte};

  // One wait state per access keeps the read mux off the bus path
  always_comb begin
    next_state       = state;
    next_waitrequest = 1'b1;
    unique case (state)
      pfdc_pkg::PFDC_BUS_IDLE: begin
        if (req) begin
          next_state       = pfdc_pkg::PFDC_BUS_ACK;
          next_waitrequest = 1'b0;
        end
      end
      pfdc_pkg::PFDC_BUS_ACK: begin
        next_state = pfdc_pkg::PFDC_BUS_IDLE;
      end
    endcase
  end

  // Bus handshake flops
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state           <= pfdc_pkg::PFDC_BUS_IDLE;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h00000000;
    end else begin
      state           <= next_state;
      AVS_WAITREQUEST <= next_waitrequest;
      if (state == pfdc_pkg::PFDC_BUS_IDLE && AVS_READ) begin
        AVS_READDATA <= next_readdata;
      end
    end
  end

  // Port-1 function select
  always_ff @(posedge CLK) begin
    if (SRST) begin
      port1_function_select <= `PFDC_RST_REG;
    end else if (wr_p1_func) begin
      port1_function_select <= wr_byte;
    end
  end

  // Port-2 select and precedence; bit 7 never stores
  always_ff @(posedge CLK) begin
    if (SRST) begin
      port2_select_and_priority <= `PFDC_RST_REG;
    end else if (wr_p2_selpri) begin
      port2_select_and_priority <= wr_byte & `PFDC_P2_WMASK;
    end
  end

  // Direction registers
  always_ff @(posedge CLK) begin
    if (SRST) begin
      port0_direction <= `PFDC_RST_REG;
      port1_direction <= `PFDC_RST_REG;
    end else begin
      if (wr_p0_dir) begin
        port0_direction <= wr_byte;
      end
      if (wr_p1_dir) begin
        port1_direction <= wr_byte;
      end
    end
  end

  // Location bits, driven out so each peripheral claims its own pins
  always_ff @(posedge CLK) begin
    if (SRST) begin
      peripheral_location_config <= `PFDC_RST_REG;
      LOC_CFG                    <= `PFDC_RST_REG;
    end else begin
      if (wr_loc) begin
        peripheral_location_config <= wr_byte & `PFDC_LOC_WMASK;
      end
      LOC_CFG <= (wr_loc) ? (wr_byte & `PFDC_LOC_WMASK) : peripheral_location_config;
    end
  end

  // Feed the arbiter through the shared carrier
  assign cfg.p2_selpri = port2_select_and_priority;
  assign cfg.claim     = PER_CLAIM & {5{port1_function_select}};
  assign cfg.per_out   = PER_OUT;
  assign cfg.per_oe    = PER_OE;

  pfdc_p1_arb u_arb (
    .cfg (cfg.arb)
  );

  pfdc_p2_mux u_p2 (
    .cfg       (cfg.p2),
    .gp_data   (P2_DATA),
    .gp_dir    (P2_DIR),
    .per_out   (P2_PER_OUT),
    .per_oe    (P2_PER_OE),
    .lfosc_sel (LFOSC_SEL),
    .dbg_act   (DBG_ACTIVE),
    .dbg_dout  (DBG_DATA_OUT),
    .dbg_drive (DBG_DATA_DRIVE),
    .pad_out   (p2_out),
    .pad_drv   (p2_drv),
    .pad_ana   (p2_ana)
  );

  // Port 0: function select comes from outside, direction from here
  assign next_p0_out = (P0_FUNC & P0_PER_OUT) | (~P0_FUNC & P0_DATA);
  assign next_p0_drv = (P0_FUNC & P0_PER_OE) | (~P0_FUNC & port0_direction);

  // Port 1: a peripheral pin nobody claims is left undriven
  assign next_p1_out = (port1_function_select & cfg.pin_out)
                     | (~port1_function_select & P1_DATA);
  assign next_p1_drv = (port1_function_select & cfg.pin_oe & cfg.pin_held)
                     | (~port1_function_select & port1_direction);

  // Pad flops; one cycle of latency buys clean outputs at the pads
  always_ff @(posedge CLK) begin
    if (SRST) begin
      P0_PAD_OUT  <= `PFDC_RST_REG;
      P0_PAD_OE_N <= `PFDC_RST_OE_N;
      P1_PAD_OUT  <= `PFDC_RST_REG;
      P1_PAD_OE_N <= `PFDC_RST_OE_N;
      PER_GRANT   <= 40'h0000000000;
    end else begin
      P0_PAD_OUT  <= next_p0_out;
      P0_PAD_OE_N <= ~next_p0_drv;
      P1_PAD_OUT  <= next_p1_out;
      P1_PAD_OE_N <= ~next_p1_drv;
      PER_GRANT   <= cfg.grant;
    end
  end

  // Port-2 pad flops; analog pins are never driven
  always_ff @(posedge CLK) begin
    if (SRST) begin
      P2_PAD_OUT  <= 5'h00;
      P2_PAD_OE_N <= `PFDC_RST_P2_OE_N;
      P2_ANALOG   <= 5'h00;
    end else begin
      P2_PAD_OUT  <= p2_out;
      P2_PAD_OE_N <= ~p2_drv;
      P2_ANALOG   <= p2_ana;
    end
  end
endmodule

/* File: verif/pfdc_periph_model.sv */
module pfdc_periph_model (
  input  wire logic [39:0] claim_map, // Pins each slot wants
  output logic      [39:0] per_claim, // Claims to the block
  output logic      [39:0] per_out,   // Slot pin values
  output logic      [39:0] per_oe     // Slot drive requests
);
  timeunit 1ns;
  timeprecision 1ps;
  // Placement comes from claim_map; peripherals drive whenever placed
  assign per_claim = claim_map;
  assign per_oe    = claim_map;
  // Pin-0 values differ within each tested pair, so the pad shows who won
  assign per_out   = {8'h55, 8'hc3, 8'h3c, 8'hf0, 8'h0f};
endmodule

/* File: verif/pfdc_top_asserts.sv */
module pfdc_top_asserts (
  input wire logic        CLK,
  input wire logic        SRST,
  input wire logic [9:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic [7:0]  LOC_CFG,
  input wire logic [39:0] PER_CLAIM,
  input wire logic [39:0] PER_GRANT,
  input wire logic [7:0]  P1_PAD_OE_N,
  input wire logic [4:0]  P2_PAD_OUT,
  input wire logic [4:0]  P2_PAD_OE_N,
  input wire logic [4:0]  P2_ANALOG,
  input wire logic        LFOSC_SEL,
  input wire logic        DBG_ACTIVE,
  input wire logic        DBG_DATA_OUT,
  input wire logic        DBG_DATA_DRIVE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  // A taken request is answered once, then the stall comes back
  sequence s_req;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence s_ack;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence
  a_bus_one_wait: assert property (s_req |=> s_ack)
    else $error("bus answer not after one wait");
  a_idle_stall: assert property (!(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("stall dropped without request");
  a_spare_bit_zero: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[9:2] == 8'hf5
    |-> AVS_READDATA[31:7] == 25'h0)
    else $error("port-2 spare bit read nonzero");
  a_loc_reserved: assert property ((LOC_CFG & 8'h8c) == 8'h00)
    else $error("reserved location bit set");
  a_osc_analog: assert property (!SRST |=> P2_ANALOG == {{2{$past(LFOSC_SEL)}}, 3'b000})
    else $error("analog mode wrong");
  a_osc_pins_off: assert property (!SRST && LFOSC_SEL |=>
    P2_PAD_OE_N[4:3] == 2'b11 && P2_PAD_OUT[4:3] == 2'b00)
    else $error("oscillator pins driven");
  a_dbg_clock_in: assert property (!SRST && DBG_ACTIVE |=> P2_PAD_OE_N[2])
    else $error("debug clock pin driven");
  a_dbg_data_out: assert property (!SRST && DBG_ACTIVE && DBG_DATA_DRIVE |=>
    !P2_PAD_OE_N[1] && P2_PAD_OUT[1] == $past(DBG_DATA_OUT))
    else $error("debug data not driven");
  a_grant_claimed: assert property (!SRST |=> (PER_GRANT & ~$past(PER_CLAIM)) == 40'h0)
    else $error("grant without claim");
  a_reset_idle: assert property (disable iff (1'b0) SRST |=>
    AVS_WAITREQUEST && P1_PAD_OE_N == 8'hff && PER_GRANT == 40'h0)
    else $error("reset state wrong");
endmodule
bind pfdc_top pfdc_top_asserts u_chk (.CLK(CLK), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .LOC_CFG(LOC_CFG), .PER_CLAIM(PER_CLAIM),
  .PER_GRANT(PER_GRANT), .P1_PAD_OE_N(P1_PAD_OE_N), .P2_PAD_OUT(P2_PAD_OUT),
  .P2_PAD_OE_N(P2_PAD_OE_N), .P2_ANALOG(P2_ANALOG), .LFOSC_SEL(LFOSC_SEL),
  .DBG_ACTIVE(DBG_ACTIVE), .DBG_DATA_OUT(DBG_DATA_OUT), .DBG_DATA_DRIVE(DBG_DATA_DRIVE));

/* File: verif/test_port_function_direction_ctrl.sv */
module test_port_function_direction_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] idx; logic [7:0] wd; logic [7:0] rd;} pfdc_reg_s;
  typedef struct packed {logic [7:0] pri; logic [2:0] a; logic [2:0] b; logic [2:0] w;
    logic p0;} pfdc_arb_s;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [9:0]  adr = 10'h000;
  logic        rd_q = 1'b0, wr_q = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  be = 4'hf;
  logic [7:0]  p0_data = 8'h00, p0_func = 8'h00, p0_pout = 8'h00, p0_poe = 8'h00;
  logic [7:0]  p1_data = 8'h00;
  logic [39:0] claim_map = 40'h0;
  logic [4:0]  p2_data = 5'h00, p2_dir = 5'h00, p2_pout = 5'h00, p2_poe = 5'h00;
  logic        lfosc = 1'b0, dbg_act = 1'b0, dbg_dout = 1'b0, dbg_drv = 1'b0;
  logic [31:0] rdata, rq;
  logic        wait_q;
  logic [7:0]  loc, p0_out, p0_oen, p1_out, p1_oen;
  logic [39:0] claim, pout, poe, grant;
  logic [4:0]  p2_out, p2_oen, p2_ana;
  int          error_cnt = 0, n_checks = 0, cyc = 0;
  pfdc_reg_s   regs [6] = '{'{8'hf4, 8'ha5, 8'ha5}, '{8'hf5, 8'hff, 8'h7f},
    '{8'hfd, 8'h5a, 8'h5a}, '{8'hfe, 8'hc3, 8'hc3}, '{8'hf1, 8'hff, 8'h73},
    '{8'h20, 8'hff, 8'h00}};
  // Contending pairs on pin 0, winner worked out from each precedence bit
  pfdc_arb_s   arbs [8] = '{'{8'h00, 3'd0, 3'd1, 3'd0, 1'b1}, '{8'h40, 3'd0, 3'd1, 3'd1, 1'b0},
    '{8'h00, 3'd1, 3'd3, 3'd1, 1'b0}, '{8'h20, 3'd1, 3'd3, 3'd3, 1'b1},
    '{8'h00, 3'd2, 3'd4, 3'd2, 1'b0}, '{8'h10, 3'd2, 3'd4, 3'd4, 1'b1},
    '{8'h00, 3'd0, 3'd2, 3'd0, 1'b1}, '{8'h08, 3'd0, 3'd2, 3'd2, 1'b0}};

  pfdc_top DUT (.CLK(clk), .SRST(srst), .AVS_ADDRESS(adr), .AVS_READ(rd_q), .AVS_WRITE(wr_q),
    .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_q),
    .LOC_CFG(loc), .P0_DATA(p0_data), .P0_FUNC(p0_func), .P0_PER_OUT(p0_pout),
    .P0_PER_OE(p0_poe), .P0_PAD_OUT(p0_out), .P0_PAD_OE_N(p0_oen), .P1_DATA(p1_data),
    .PER_CLAIM(claim), .PER_OUT(pout), .PER_OE(poe), .PER_GRANT(grant), .P1_PAD_OUT(p1_out),
    .P1_PAD_OE_N(p1_oen), .P2_DATA(p2_data), .P2_DIR(p2_dir), .P2_PER_OUT(p2_pout),
    .P2_PER_OE(p2_poe), .LFOSC_SEL(lfosc), .DBG_ACTIVE(dbg_act), .DBG_DATA_OUT(dbg_dout),
    .DBG_DATA_DRIVE(dbg_drv), .P2_PAD_OUT(p2_out), .P2_PAD_OE_N(p2_oen), .P2_ANALOG(p2_ana));
  pfdc_periph_model u_per (.claim_map(claim_map), .per_claim(claim), .per_out(pout),
    .per_oe(poe));

  always #2 clk = ~clk;
  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One Avalon access; request held until the stall is seen low
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     input logic [3:0] en);
    @(posedge clk);
    adr <= {idx, 2'b00};
    wr_q <= w;
    rd_q <= !w;
    wdat <= {24'h0, d};
    be <= en;
    // No fixed latency assumed; only the hang guard ends this wait
    do begin
      @(posedge clk);
    end while (wait_q !== 1'b0);
    rq = rdata;
    wr_q <= 1'b0;
    rd_q <= 1'b0;
  endtask
  // Pads follow their cause one edge later
  task automatic settle;
    @(posedge clk);
    #1;
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    #1;
    check(p0_oen, 8'hff);
    check(p1_oen, 8'hff);
    check(grant, 40'h0);
    foreach (regs[i]) begin
      bus(1'b0, regs[i].idx, 8'h00, 4'h0);
      check(rq, 32'h0);
      bus(1'b1, regs[i].idx, regs[i].wd, 4'h1);
      bus(1'b0, regs[i].idx, 8'h00, 4'h0);
      check(rq, {24'h0, regs[i].rd});
    end
    check(loc, 8'h73);
    bus(1'b1, 8'hf4, 8'h00, 4'h0);
    bus(1'b0, 8'hf4, 8'h00, 4'h0);
    check(rq, 32'ha5);
    // Port 0: direction, then peripheral override on pins 7 and 0
    bus(1'b1, 8'hfd, 8'h8f, 4'h1);
    p0_data <= 8'h3c;
    settle();
    check(p0_oen, 8'h70);
    check(p0_out & 8'h8f, 8'h0c);
    @(posedge clk);
    p0_func <= 8'h81;
    p0_poe <= 8'h01;
    p0_pout <= 8'h55;
    settle();
    check(p0_oen, 8'hf0);
    check(p0_out & 8'h01, 8'h01);
    // Port 1 as plain outputs: claims must not win anything
    bus(1'b1, 8'hf4, 8'h00, 4'h1);
    bus(1'b1, 8'hfe, 8'hff, 4'h1);
    p1_data <= 8'h99;
    claim_map <= 40'h1;
    settle();
    check(p1_oen, 8'h00);
    check(p1_out, 8'h99);
    check(grant, 40'h0);
    bus(1'b1, 8'hfe, 8'h00, 4'h1);
    bus(1'b1, 8'hf4, 8'hff, 4'h1);
    foreach (arbs[i]) begin
      bus(1'b1, 8'hf5, arbs[i].pri, 4'h1);
      claim_map <= (40'h1 << (arbs[i].a * 8)) | (40'h1 << (arbs[i].b * 8)) | (40'h1 << 29);
      settle();
      check(grant, (40'h1 << (arbs[i].w * 8)) | (40'h1 << 29));
      check(p1_oen, 8'hde);
      check(p1_out & 8'h21, {7'h0, arbs[i].p0});
    end
    bus(1'b1, 8'hf4, 8'hfe, 4'h1);
    settle();
    check(grant, 40'h1 << 29);
    check(p1_oen, 8'hdf);
    bus(1'b0, 8'hf9, 8'h00, 4'h0);
    check(rq, 32'h20);
    // Port 2: function bits, then oscillator, then debug takeover
    bus(1'b1, 8'hf5, 8'h07, 4'h1);
    p2_dir <= 5'h1f;
    p2_data <= 5'h15;
    p2_pout <= 5'h0a;
    p2_poe <= 5'h11;
    settle();
    check(p2_oen, 5'h08);
    check(p2_out & 5'h17, 5'h04);
    @(posedge clk);
    lfosc <= 1'b1;
    settle();
    check(p2_ana, 5'h18);
    check(p2_oen, 5'h18);
    @(posedge clk);
    lfosc <= 1'b0;
    dbg_act <= 1'b1;
    dbg_drv <= 1'b1;
    dbg_dout <= 1'b1;
    settle();
    check(p2_oen, 5'h0c);
    check(p2_out[1], 1'b1);
    @(posedge clk);
    // Second reset in mid-run clears everything again
    srst <= 1'b1;
    dbg_act <= 1'b0;
    @(posedge clk);
    srst <= 1'b0;
    #1;
    check(p1_oen, 8'hff);
    bus(1'b0, 8'hf4, 8'h00, 4'h0);
    check(rq, 32'h0);
    wrap_up();
  end
endmodule
